// ===== mpm_defs.svh
// Constants for the modulator power mode control block
`ifndef MPM_DEFS_SVH
`define MPM_DEFS_SVH

// Register indices
`define MPM_ADDR_VERSION 8'h00
`define MPM_ADDR_AMP1 8'h01
`define MPM_ADDR_AMP2 8'h02
`define MPM_ADDR_MOD 8'h03
`define MPM_ADDR_PWR 8'h04

// Reset values of the configuration registers
`define MPM_RST_AMP1 8'h00
`define MPM_RST_AMP2 8'h00
`define MPM_RST_MOD 8'h00
`define MPM_RST_PWR 8'h30

// Power-down bit positions in the power configuration register
`define MPM_POWER_DOWN_BIT_BIT_CH0 4
`define MPM_POWER_DOWN_BIT_BIT_CH1 5

// Timing
`define MPM_CLK_PERIOD_NS 4
`define MPM_LOSS_TIME_NS 40000
`define MPM_LOSS_CYCLES ((`MPM_LOSS_TIME_NS + `MPM_CLK_PERIOD_NS - 1) / `MPM_CLK_PERIOD_NS)
`define MPM_MOD_DIV 4

`endif

// ===== mpm_pkg.sv
// Types for the modulator power mode control block
package mpm_pkg;

    typedef enum logic [1:0] {
        MPM_ST_NORMAL = 2'b00,
        MPM_ST_PD_CMD = 2'b01,
        MPM_ST_PD_CLKLOSS = 2'b10
    } mpm_power_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mpm_reg_req_t;

    typedef struct packed {
        logic [7:0] amp1;
        logic [7:0] amp2;
        logic [7:0] modcfg;
        logic [7:0] power_config_register;
    } mpm_cfg_t;

endpackage

// ===== mpm_power_ctrl.sv
// Power mode control, loss-of-clock detector and modulator stream gating
`timescale 1ns/1ps
`include "mpm_defs.svh"

module mpm_power_ctrl #(
    parameter int LOSS_CYCLES = `MPM_LOSS_CYCLES,
    parameter int CNT_W = 16,
    parameter int MOD_DIV = `MPM_MOD_DIV,
    parameter logic [7:0] VERSION_ID = 8'h01 // Arbitrary value
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Master clock from the filter
    input wire logic mclk,
    // Register access
    input wire mpm_pkg::mpm_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Modulator bits from the analog side, per channel
    input wire logic [1:0] mod_sample,
    // Bit stream pins toward the filter
    output logic [1:0] mod_data,
    output logic [1:0] mod_data_oe,
    // Power status
    output mpm_pkg::mpm_power_state_t power_state,
    output logic [1:0] chan_active,
    output logic [1:0] analog_in_hiz
);
    import mpm_pkg::*;

    mpm_cfg_t cfg_ff;
    logic [7:0] rdata_ff;
    logic [CNT_W-1:0] idle_cnt_ff;
    logic clk_lost_ff;
    logic tog_s1_ff, tog_s2_ff, tog_s3_ff;
    logic mclk_edge;
    logic [1:0] power_down_bit;
    logic [1:0] chan_en_ff;
    logic [1:0] oe_ff;
    logic [1:0] hiz_ff;
    mpm_power_state_t state_ff;
    mpm_power_state_t nxt_state;
    // Link domain
    logic mrst_s1_ff, mrst_s2_ff;
    logic mclk_tog_ff;
    logic [1:0] en_s1_ff, en_s2_ff;
    logic [1:0] smp_s1_ff, smp_s2_ff;
    logic [1:0] data_ff;
    logic [7:0] div_ff;
    logic mod_tick;

    assign power_down_bit = {cfg_ff.power_config_register[`MPM_POWER_DOWN_BIT_BIT_CH1], cfg_ff.power_config_register[`MPM_POWER_DOWN_BIT_BIT_CH0]};
    assign mclk_edge = tog_s2_ff ^ tog_s3_ff;

    // Register writes; ignored while the logic sleeps for lack of a clock
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cfg_ff <= '{amp1: `MPM_RST_AMP1, amp2: `MPM_RST_AMP2, modcfg: `MPM_RST_MOD, power_config_register: `MPM_RST_PWR};
        end else if (reg_req.wr && !clk_lost_ff) begin
            case (reg_req.addr)
                `MPM_ADDR_AMP1: cfg_ff.amp1 <= reg_req.wdata;
                `MPM_ADDR_AMP2: cfg_ff.amp2 <= reg_req.wdata;
                `MPM_ADDR_MOD: cfg_ff.modcfg <= reg_req.wdata;
                `MPM_ADDR_PWR: cfg_ff.power_config_register <= reg_req.wdata;
                default: cfg_ff <= cfg_ff; // Version is read-only
            endcase
        end
    end

    // Register reads; unmapped indices return zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_req.rd && !clk_lost_ff) begin
            case (reg_req.addr)
                `MPM_ADDR_VERSION: rdata_ff <= VERSION_ID;
                `MPM_ADDR_AMP1: rdata_ff <= cfg_ff.amp1;
                `MPM_ADDR_AMP2: rdata_ff <= cfg_ff.amp2;
                `MPM_ADDR_MOD: rdata_ff <= cfg_ff.modcfg;
                `MPM_ADDR_PWR: rdata_ff <= cfg_ff.power_config_register;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    // Master clock activity toggle brought into the core domain
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tog_s1_ff <= 1'b0;
            tog_s2_ff <= 1'b0;
            tog_s3_ff <= 1'b0;
        end else begin
            tog_s1_ff <= mclk_tog_ff;
            tog_s2_ff <= tog_s1_ff;
            tog_s3_ff <= tog_s2_ff;
        end
    end

    // Loss timer on the core clock, so it keeps counting when mclk stops
    // Reset leaves the device in clock loss, the filter starts with mclk off
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            idle_cnt_ff <= '0;
            clk_lost_ff <= 1'b1;
        end else if (mclk_edge) begin
            idle_cnt_ff <= '0;
            clk_lost_ff <= 1'b0;
        end else if (idle_cnt_ff == CNT_W'(LOSS_CYCLES - 1)) begin
            clk_lost_ff <= 1'b1;
        end else begin
            idle_cnt_ff <= idle_cnt_ff + 1'b1;
        end
    end

    // Per-channel enables, pin drive and analog input float, all from the core side
    // The pin enable lives here because the link domain freezes once mclk stops
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chan_en_ff <= 2'b00;
            oe_ff <= 2'b00;
            hiz_ff <= 2'b11;
        end else begin
            chan_en_ff <= ~power_down_bit & {2{~clk_lost_ff}};
            oe_ff <= ~power_down_bit & {2{~clk_lost_ff}};
            hiz_ff <= power_down_bit | {2{clk_lost_ff}};
        end
    end

    // Device power state
    always_comb begin
        if (clk_lost_ff) begin
            nxt_state = MPM_ST_PD_CLKLOSS;
        end else if (&power_down_bit) begin
            nxt_state = MPM_ST_PD_CMD;
        end else begin
            nxt_state = MPM_ST_NORMAL;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= MPM_ST_PD_CLKLOSS;
        end else begin
            case (nxt_state)
                MPM_ST_NORMAL: state_ff <= MPM_ST_NORMAL;
                MPM_ST_PD_CMD: state_ff <= MPM_ST_PD_CMD;
                MPM_ST_PD_CLKLOSS: state_ff <= MPM_ST_PD_CLKLOSS;
                default: state_ff <= MPM_ST_PD_CLKLOSS;
            endcase
        end
    end

    assign reg_rdata = rdata_ff;
    assign mod_data_oe = oe_ff;
    assign power_state = state_ff;
    assign chan_active = chan_en_ff;
    assign analog_in_hiz = hiz_ff;

    // Link domain reset taken from the core reset through two flops
    always_ff @(posedge mclk) begin
        mrst_s1_ff <= rst_n;
        mrst_s2_ff <= mrst_s1_ff;
    end

    // Toggle on every rising mclk edge for the activity detector
    always_ff @(posedge mclk) begin
        if (!mrst_s2_ff) begin
            mclk_tog_ff <= 1'b0;
        end else begin
            mclk_tog_ff <= ~mclk_tog_ff;
        end
    end

    // Channel enables and analog bits synchronised into the link domain
    always_ff @(posedge mclk) begin
        if (!mrst_s2_ff) begin
            en_s1_ff <= 2'b00;
            en_s2_ff <= 2'b00;
            smp_s1_ff <= 2'b00;
            smp_s2_ff <= 2'b00;
        end else begin
            en_s1_ff <= chan_en_ff;
            en_s2_ff <= en_s1_ff;
            smp_s1_ff <= mod_sample;
            smp_s2_ff <= smp_s1_ff;
        end
    end

    // Stream rate divider: one bit per MOD_DIV mclk cycles
    assign mod_tick = (div_ff == 8'(MOD_DIV - 1));

    always_ff @(posedge mclk) begin
        if (!mrst_s2_ff || mod_tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // Bit stream per channel; a channel disabled while mclk runs holds zero behind its float
    always_ff @(posedge mclk) begin
        if (!mrst_s2_ff) begin
            data_ff <= 2'b00;
        end else if (mod_tick) begin
            data_ff <= smp_s2_ff & en_s2_ff;
        end
    end

    assign mod_data = data_ff;

    // Checks in the core domain
    a_loss_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
        (idle_cnt_ff == CNT_W'(LOSS_CYCLES - 1) && !mclk_edge) |=> clk_lost_ff)
        else $error("clock loss not flagged at timeout");
    a_loss_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        mclk_edge |=> (!clk_lost_ff && idle_cnt_ff == '0))
        else $error("clock loss not cleared on mclk edge");
    a_loss_floats_pins: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_lost_ff |=> (mod_data_oe == 2'b00 && analog_in_hiz == 2'b11))
        else $error("pins driven during clock loss");
    a_power_down_bit_floats_chan: assert property (@(posedge core_clk) disable iff (!rst_n)
        power_down_bit[0] |=> (!mod_data_oe[0] && analog_in_hiz[0] && !chan_active[0]))
        else $error("channel 0 active while powered down");
    a_chan_independent: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!clk_lost_ff && !power_down_bit[1] && power_down_bit[0]) |=> (mod_data_oe == 2'b10))
        else $error("channel 1 not independent of channel 0");
    a_lost_write_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_lost_ff && reg_req.wr) |=> $stable(cfg_ff))
        else $error("register changed during clock loss");
    a_pwr_write_taken: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!clk_lost_ff && reg_req.wr && reg_req.addr == `MPM_ADDR_PWR) |=> ##1
        (mod_data_oe[0] == !$past(reg_req.wdata[`MPM_POWER_DOWN_BIT_BIT_CH0], 2) || clk_lost_ff))
        else $error("power-down bit write not applied");
    a_version_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!clk_lost_ff && reg_req.rd && reg_req.addr == `MPM_ADDR_VERSION) |=> reg_rdata == VERSION_ID)
        else $error("version read wrong");
    a_cmd_pd_access: assert property (@(posedge core_clk) disable iff (!rst_n)
        (power_state == MPM_ST_PD_CMD && !clk_lost_ff && reg_req.rd && reg_req.addr == `MPM_ADDR_PWR)
        |=> reg_rdata == $past(cfg_ff.power_config_register))
        else $error("register read failed in commanded power-down");
    a_state_tracks: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_lost_ff |=> power_state == MPM_ST_PD_CLKLOSS)
        else $error("state not clock-loss power-down");

    // Power state and pin enables against the power-down bits, then read and register hold checks
    // Only both bits together count as commanded power-down; one channel down is still normal
    a_cmd_pd_state: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!clk_lost_ff && &power_down_bit) |=> power_state == MPM_ST_PD_CMD)
        else $error("state not commanded power-down");
    a_normal_state: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!clk_lost_ff && !(&power_down_bit)) |=> power_state == MPM_ST_NORMAL)
        else $error("state not normal with a channel running");
    a_power_down_bit_floats_ch1: assert property (@(posedge core_clk) disable iff (!rst_n)
        power_down_bit[1] |=> (!mod_data_oe[1] && analog_in_hiz[1] && !chan_active[1]))
        else $error("channel 1 active while powered down");
    a_run_enables_ch0: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!clk_lost_ff && !power_down_bit[0]) |=> (mod_data_oe[0] && chan_active[0] && !analog_in_hiz[0]))
        else $error("channel 0 not running with clock and bit cleared");
    a_run_enables_ch1: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!clk_lost_ff && !power_down_bit[1]) |=> (mod_data_oe[1] && chan_active[1] && !analog_in_hiz[1]))
        else $error("channel 1 not running with clock and bit cleared");
    a_lost_read_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        (clk_lost_ff && reg_req.rd) |=> $stable(reg_rdata))
        else $error("read data changed during clock loss");
    a_reg_retained: assert property (@(posedge core_clk) disable iff (!rst_n)
        !reg_req.wr |=> $stable(cfg_ff))
        else $error("register changed without a write");

    // Checks in the link domain
    a_stream_rate: assert property (@(posedge mclk) disable iff (!mrst_s2_ff)
        mod_tick |=> !mod_tick [*3] ##1 mod_tick)
        else $error("stream bit spacing wrong");
    a_stream_gated: assert property (@(posedge mclk) disable iff (!mrst_s2_ff)
        (mod_tick && !en_s2_ff[0]) |=> !mod_data[0])
        else $error("disabled channel 0 sent a one");

    c_enter_loss: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(clk_lost_ff));
    c_leave_loss: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(clk_lost_ff));
    c_normal: cover property (@(posedge core_clk) disable iff (!rst_n) power_state == MPM_ST_NORMAL);
    c_cmd_pd: cover property (@(posedge core_clk) disable iff (!rst_n) power_state == MPM_ST_PD_CMD);
    c_one_chan: cover property (@(posedge core_clk) disable iff (!rst_n) (!clk_lost_ff && power_down_bit == 2'b01));

endmodule // mpm_power_ctrl

// ===== mpm_filter_model.sv
// Filter-side model: master clock source and stream receiver
`timescale 1ns/1ps
module mpm_filter_model (
    // Clock control from the bench
    input wire logic mclk_en,
    output logic mclk,
    // Stream pins from the device
    input wire logic [1:0] mod_data,
    input wire logic [1:0] mod_data_oe,
    output logic [1:0] pin_val
);
    logic [1:0] last_ff = 2'h0;

    // Clock stands low while disabled and runs whenever mclk_en is high; the model has no reset
    initial begin
        mclk = 1'b0;
        #7;
        forever begin
            #24;
            mclk = mclk_en ? ~mclk : 1'b0;
        end
    end

    // No pull on the line: a floated pin shows the inverse of the last level
    assign pin_val = (mod_data & mod_data_oe) | (~last_ff & ~mod_data_oe);

    // Remember the level seen at each link edge
    always @(posedge mclk) begin
        last_ff <= pin_val;
    end
endmodule // mpm_filter_model

// ===== tb.sv
// Self-checking bench for the power mode control block
`timescale 1ns/1ps
`include "mpm_defs.svh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module tb;
    import mpm_pkg::*;
    localparam int LOSS = 50;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mclk_en = 1'b1;
    logic mclk;
    mpm_reg_req_t reg_req = '0;
    logic [7:0] reg_rdata;
    logic [1:0] mod_sample = 2'h0;
    logic [1:0] mod_data, mod_data_oe, chan_active, analog_in_hiz, pin_val;
    mpm_power_state_t power_state;
    int error_cnt = 0;
    int checks_done = 0;
    logic [15:0] lfsr = 16'h36ed;
    logic [7:0] exp_q[$];
    logic [7:0] exp_v;
    logic rd_pend = 1'b0;
    logic [23:0] sec_cmd = '0;
    logic [23:0] sec_dat = '0;
    logic [7:0] pv[3] = '{8'h8f, 8'h9f, 8'haf};
    logic [1:0] msk[3] = '{2'h3, 2'h2, 2'h1};

    initial forever #2 core_clk = ~core_clk;

    mpm_power_ctrl #(.LOSS_CYCLES(LOSS)) DUT (.core_clk(core_clk), .rst_n(rst_n), .mclk(mclk),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .mod_sample(mod_sample), .mod_data(mod_data),
        .mod_data_oe(mod_data_oe), .power_state(power_state), .chan_active(chan_active),
        .analog_in_hiz(analog_in_hiz));
    mpm_filter_model filt (.mclk_en(mclk_en), .mclk(mclk), .mod_data(mod_data),
        .mod_data_oe(mod_data_oe), .pin_val(pin_val));

    function automatic logic [15:0] nx(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic cyc(int n);
        repeat (n) @(negedge core_clk);
    endtask

    // One-cycle strobe, taken at the next rising edge
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        reg_req <= '{w, ~w, a, d};
        @(negedge core_clk);
        reg_req <= '0;
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask

    // Filter side of one host write-register step into a secondary holder
    task automatic host_step(logic [23:0] tgt, logic [23:0] val);
        cyc(2); // Request flag polled between steps
        case (tgt)
            24'h00_0011: sec_cmd = val;
            24'h00_0012: sec_dat = val;
            24'h00_0010: begin
                if (val == 24'h3F_0161 && sec_cmd[15:8] == 8'h02) begin
                    acc(1'b1, sec_cmd[7:0], sec_dat[23:16]);
                end
            end
            default: ;
        endcase
    endtask

    // Host sequence: command holder, data holder, then a start per device select
    task automatic host_cfg(logic [23:0] cmd, logic [23:0] dat);
        host_step(24'h00_0011, cmd);
        host_step(24'h00_0012, dat);
        host_step(24'h00_0010, 24'h3F_0161);
        host_step(24'h00_0010, 24'h3F_4162); // Second select has no device here
    endtask

    task automatic st(mpm_power_state_t s, logic [1:0] act, logic [1:0] hiz);
        `CHK("power_state", s, power_state)
        `CHK("chan_active", act, chan_active)
        `CHK("mod_data_oe", act, mod_data_oe)
        `CHK("analog_in_hiz", hiz, analog_in_hiz)
    endtask

    // Bounded wait for the loss flag to clear once the clock runs
    task automatic up();
        int i;
        mclk_en <= 1'b1;
        for (i = 0; i < 200 && power_state === MPM_ST_PD_CLKLOSS; i++) cyc(1);
        cyc(8);
    endtask

    // Read results come back on the strobe edge and are checked at the next falling edge
    always @(posedge core_clk) rd_pend <= reg_req.rd;
    always @(negedge core_clk) begin
        if (rd_pend) begin
            exp_v = exp_q.pop_front();
            `CHK("reg_rdata", exp_v, reg_rdata)
        end
    end

    task automatic tally_and_finish();
        if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run of a few thousand cycles
    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        cyc(20);
        rst_n <= 1'b1;
        mclk_en <= 1'b0;
        cyc(LOSS + 20);
        st(MPM_ST_PD_CLKLOSS, 2'h0, 2'h3);
        acc(1'b1, `MPM_ADDR_PWR, 8'h00);
        up();
        st(MPM_ST_PD_CMD, 2'h0, 2'h3);
        rd(`MPM_ADDR_PWR, `MPM_RST_PWR);
        acc(1'b1, `MPM_ADDR_VERSION, 8'hff);
        rd(`MPM_ADDR_VERSION, 8'h01);
        rd(8'h07, 8'h00);
        lfsr = nx(lfsr);
        acc(1'b1, `MPM_ADDR_AMP1, lfsr[7:0]);
        rd(`MPM_ADDR_AMP1, lfsr[7:0]);
        host_cfg(24'h00_0203, 24'h40_0000);
        rd(`MPM_ADDR_MOD, 8'h40);
        // Both channels, then each one alone, with random stream bits
        for (int k = 0; k < 3; k++) begin
            host_cfg(24'h00_0204, {pv[k], 16'h0000});
            cyc(4);
            st(MPM_ST_NORMAL, msk[k], ~msk[k]);
            repeat (3) begin
                lfsr = nx(lfsr);
                mod_sample <= lfsr[1:0];
                cyc(200);
                `CHK("pin_val", mod_sample & msk[k], pin_val & msk[k])
                `CHK("mod_data", mod_sample & msk[k], mod_data)
            end
        end
        acc(1'b1, `MPM_ADDR_PWR, 8'hbf);
        cyc(4);
        st(MPM_ST_PD_CMD, 2'h0, 2'h3);
        rd(`MPM_ADDR_PWR, 8'hbf);
        acc(1'b1, `MPM_ADDR_PWR, 8'h8f);
        cyc(4);
        mclk_en <= 1'b0;
        cyc(30);
        st(MPM_ST_NORMAL, 2'h3, 2'h0);
        cyc(40);
        st(MPM_ST_PD_CLKLOSS, 2'h0, 2'h3);
        up();
        rd(`MPM_ADDR_PWR, 8'h8f);
        st(MPM_ST_NORMAL, 2'h3, 2'h0);
        // Held long enough for three link edges, so the link side resets too
        rst_n <= 1'b0;
        cyc(40);
        rst_n <= 1'b1;
        up();
        rd(`MPM_ADDR_PWR, `MPM_RST_PWR);
        st(MPM_ST_PD_CMD, 2'h0, 2'h3);
        cyc(4);
        tally_and_finish();
    end
endmodule // tb
